/* logic/boot_cfg_map.vh */
`ifndef BOOT_CFG_MAP_VH
`define BOOT_CFG_MAP_VH
// nonvolatile location of the configuration byte
`define CFG_NV_ADDR 16'h0080
// configuration byte fields
`define CFG_FIX7 7
`define CFG_WAIT_HI 6
`define CFG_WAIT_LO 5
`define CFG_FIX4 4
`define CFG_RST_ROLE 3
`define CFG_SRC_HI 2
`define CFG_SRC_LO 1
`define CFG_LOCK 0
// stabilization exponents per wait code
`define WAIT_EXP0 5'h0a
`define WAIT_EXP1 5'h0c
`define WAIT_EXP2 5'h0f
`define WAIT_EXP3 5'h11
// clock source codes
`define SRC_XTAL 2'h0
`define SRC_EXT 2'h1
// register byte addresses
`define REG_CFG_BYTE 12'h080
`define REG_STATUS 12'h084
`define REG_SLOW_OSC 12'h088
`define REG_WD_CTRL 12'h08c
// status bits
`define ST_READY 0
`define ST_SRC_XTAL 1
`define ST_SRC_EXT 2
`define ST_SRC_HSI 3
`define ST_RST_PIN 4
`define ST_SLOW_RUN 5
`define ST_FMT_OK 6
// slow oscillator mode register: stop bit
`define SLOW_STOP_BIT 0
// watchdog control: bit0 selects slow osc as count source
`define WD_SRC_SLOW 0
// ahb codes
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`endif

/* logic/stab_wait_timer.v */
`timescale 1ns/10ps
`include "boot_cfg_map.vh"
module stab_wait_timer (
  input wire i_clk,
  input wire i_rst,
  input wire i_start,
  input wire [4:0] i_exp,
  input wire i_osc_tick,
  output reg o_done
);
  reg [17:0] cnt_q;
  reg run_q;
  wire [17:0] limit = (18'h00001 << i_exp) - 18'h00001;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 18'h00000;
      run_q <= 1'b0;
      o_done <= 1'b0;
    end else if (i_start) begin
      cnt_q <= 18'h00000;
      run_q <= 1'b1;
      o_done <= 1'b0;
    end else if (run_q && i_osc_tick) begin
      // counts main clock periods, not system cycles
      if (cnt_q == limit) begin
        run_q <= 1'b0;
        o_done <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 18'h00001;
      end
    end
  end
endmodule

/* logic/boot_option_byte_decoder.v */
// How it works
// - after reset release fetch byte at 0080h, apply before normal run
// - wait code 00..11 gives 2^10, 2^12, 2^15, 2^17 main clock periods
// - wait only with crystal source; none for internal or external clock
// - role bit 1 makes pin a reset, 0 makes it input-only port
// - low reset pin before fetch keeps device in reset regardless
// - source 00 crystal, 01 external, 1x internal high-speed
// - crystal source takes both oscillator pins from the port
// - external source takes first oscillator pin from the port
// - internal source frees both oscillator pins as port bits
// - lock 1 keeps slow oscillator running, stop writes ignored
// - lock 0 lets software stop write halt slow oscillator
// - lock 1 forces watchdog count clock to slow oscillator
// - lock 0 gates watchdog clock off in halt and stop modes
// - lock 0 and non-slow watchdog source gates watchdog clock off
// - running slow oscillator may clock timer b even in stop
`timescale 1ns/10ps
`include "boot_cfg_map.vh"
module boot_option_byte_decoder (
  input wire i_clk,
  input wire i_rst,
  // nonvolatile read port
  output reg o_nv_req,
  output reg [15:0] o_nv_addr,
  input wire i_nv_valid,
  input wire [7:0] i_nv_data,
  // pins
  input wire i_reset_pin,
  input wire i_osc_tick,
  input wire i_halt_mode,
  input wire i_stop_mode,
  // ahb-lite slave
  input wire i_hsel,
  input wire [11:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire i_hready,
  input wire [31:0] i_hwdata,
  output reg [31:0] o_hrdata,
  output reg o_hreadyout,
  output reg o_hresp,
  // decoded outputs
  output reg o_sys_reset,
  output reg o_cfg_ready,
  output reg [1:0] o_clk_src,
  output reg o_reset_pin_is_reset,
  output reg o_reset_pin_port_bit,
  output reg o_osc_pin1_is_clk,
  output reg o_osc_pin2_is_clk,
  output reg o_slow_osc_run,
  output reg o_watchdog_clk_en,
  output reg o_watchdog_src_slow,
  output reg o_eight_bit_timer_b_clk_en
);
  localparam ST_IDLE = 4'h1;
  localparam ST_FETCH = 4'h2;
  localparam ST_WAIT = 4'h4;
  localparam ST_RUN = 4'h8;

  reg [3:0] st_q;
  reg [7:0] cfg_q;
  reg slow_osc_stop_bit_q;
  reg wd_src_slow_q;
  reg pin_s1_q;
  reg pin_s2_q;
  reg tick_s1_q;
  reg tick_s2_q;
  reg tick_d1_q;
  reg wait_start_q;
  reg ph_act_q;
  reg ph_wr_q;
  reg [11:0] ph_addr_q;
  wire wait_done;
  wire slow_run;

  // decode helpers
  function [4:0] wait_exp;
    input [1:0] code;
    begin
      case (code)
        2'h0: wait_exp = `WAIT_EXP0;
        2'h1: wait_exp = `WAIT_EXP1;
        2'h2: wait_exp = `WAIT_EXP2;
        default: wait_exp = `WAIT_EXP3;
      endcase
    end
  endfunction

  function [1:0] src_of;
    input [7:0] b;
    begin
      src_of = {b[`CFG_SRC_HI], b[`CFG_SRC_LO]};
    end
  endfunction

  // pin and oscillator tick pass two flops before use
  // pin counts as low until seen high, so a pin held low through reset does not fetch until it is seen high
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_d1_q <= 1'b0;
    end else begin
      pin_s1_q <= i_reset_pin;
      pin_s2_q <= pin_s1_q;
      tick_s1_q <= i_osc_tick;
      tick_s2_q <= tick_s1_q;
      tick_d1_q <= tick_s2_q;
    end
  end

  wire osc_edge = tick_s2_q & ~tick_d1_q;

  stab_wait_timer u_wait (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(wait_start_q),
    .i_exp(wait_exp({cfg_q[`CFG_WAIT_HI], cfg_q[`CFG_WAIT_LO]})),
    .i_osc_tick(osc_edge),
    .o_done(wait_done)
  );

  // boot sequence
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      cfg_q <= 8'h00;
      o_nv_req <= 1'b0;
      o_nv_addr <= 16'h0000;
      wait_start_q <= 1'b0;
    end else begin
      wait_start_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // pin low before the fetch holds everything back
          if (pin_s2_q) begin
            st_q <= ST_FETCH;
            o_nv_req <= 1'b1;
            o_nv_addr <= `CFG_NV_ADDR;
          end
        end
        ST_FETCH: begin
          if (i_nv_valid) begin
            o_nv_req <= 1'b0;
            cfg_q <= i_nv_data;
            if (src_of(i_nv_data) == `SRC_XTAL) begin
              st_q <= ST_WAIT;
              wait_start_q <= 1'b1;
            end else begin
              st_q <= ST_RUN;
            end
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          st_q <= ST_RUN;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  wire running = (st_q == ST_RUN);
  wire lock = cfg_q[`CFG_LOCK];
  wire pin_role = cfg_q[`CFG_RST_ROLE];
  wire [1:0] src = src_of(cfg_q);
  // lock overrides any stop request
  assign slow_run = lock | ~slow_osc_stop_bit_q;
  wire fmt_ok = cfg_q[`CFG_FIX7] & cfg_q[`CFG_FIX4];

  // decoded outputs, all from flops
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sys_reset <= 1'b1;
      o_cfg_ready <= 1'b0;
      o_clk_src <= 2'h0;
      o_reset_pin_is_reset <= 1'b1;
      o_reset_pin_port_bit <= 1'b0;
      o_osc_pin1_is_clk <= 1'b0;
      o_osc_pin2_is_clk <= 1'b0;
      o_slow_osc_run <= 1'b1;
      o_watchdog_clk_en <= 1'b0;
      o_watchdog_src_slow <= 1'b0;
      o_eight_bit_timer_b_clk_en <= 1'b0;
    end else begin
      o_cfg_ready <= running;
      o_clk_src <= src;
      // before the fetch the pin always acts as reset
      o_reset_pin_is_reset <= ~running | pin_role;
      o_reset_pin_port_bit <= running & ~pin_role & pin_s2_q;
      o_sys_reset <= ~running | (pin_role & ~pin_s2_q);
      o_osc_pin1_is_clk <= ~src[1];
      o_osc_pin2_is_clk <= (src == `SRC_XTAL);
      o_slow_osc_run <= slow_run;
      o_watchdog_src_slow <= lock | wd_src_slow_q;
      if (lock) begin
        o_watchdog_clk_en <= running;
      end else begin
        o_watchdog_clk_en <= running & slow_run & wd_src_slow_q
          & ~i_halt_mode & ~i_stop_mode;
      end
      // stop mode does not gate the timer while slow osc runs
      o_eight_bit_timer_b_clk_en <= running & slow_run;
    end
  end

  // ahb-lite slave, zero wait states, always okay
  wire ah_take = i_hsel & i_hready & (i_htrans == `HTRANS_NONSEQ) & (i_hsize == `HSIZE_WORD);
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_act_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= 12'h000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (i_hready) begin
        ph_act_q <= ah_take;
        ph_wr_q <= i_hwrite;
        ph_addr_q <= i_haddr;
      end
    end
  end

  // read data prepared at address phase so it stands from a flop
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= 32'h00000000;
    end else if (ah_take && !i_hwrite) begin
      case (i_haddr)
        `REG_CFG_BYTE: o_hrdata <= {24'h000000, cfg_q};
        `REG_STATUS: o_hrdata <= {25'h0000000, fmt_ok, slow_run, pin_role,
          src[1], src == `SRC_EXT, src == `SRC_XTAL, running};
        `REG_SLOW_OSC: o_hrdata <= {31'h00000000, slow_osc_stop_bit_q};
        `REG_WD_CTRL: o_hrdata <= {31'h00000000, wd_src_slow_q};
        default: o_hrdata <= 32'h00000000;
      endcase
    end
  end

  // writes; configuration byte itself is read-only
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      slow_osc_stop_bit_q <= 1'b0;
      wd_src_slow_q <= 1'b1;
    end else if (ph_act_q && ph_wr_q) begin
      if (ph_addr_q == `REG_SLOW_OSC) begin
        slow_osc_stop_bit_q <= i_hwdata[`SLOW_STOP_BIT];
      end
      if (ph_addr_q == `REG_WD_CTRL) begin
        wd_src_slow_q <= i_hwdata[`WD_SRC_SLOW];
      end
    end
  end
endmodule

/* tb/boot_cfg_props.sv */
`timescale 1ns/10ps
module boot_cfg_props (
  input wire i_clk,
  input wire i_rst,
  input wire i_reset_pin,
  input wire o_nv_req,
  input wire [15:0] o_nv_addr,
  input wire o_hreadyout,
  input wire o_hresp,
  input wire o_sys_reset,
  input wire o_cfg_ready,
  input wire [1:0] o_clk_src,
  input wire o_reset_pin_is_reset,
  input wire o_osc_pin1_is_clk,
  input wire o_osc_pin2_is_clk,
  input wire o_watchdog_clk_en,
  input wire o_watchdog_src_slow
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // two cycles of run so output flops have all settled
  sequence run_s;
    o_cfg_ready && $past(o_cfg_ready);
  endsequence
  sequence pin_stall_s;
    (!i_reset_pin && !o_cfg_ready && !o_nv_req) [*4];
  endsequence
  fetch_addr_a: assert property (o_nv_req |-> o_nv_addr == 16'h0080)
    else $error("fetch address wrong");
  no_wait_a: assert property ($fell(o_nv_req) ##1 (o_clk_src != 2'h0) |-> ##[0:2] o_cfg_ready)
    else $error("non-crystal source waited");
  xtal_pins_a: assert property (run_s ##0 (o_clk_src == 2'h0) |-> o_osc_pin1_is_clk && o_osc_pin2_is_clk)
    else $error("crystal pins not clock");
  ext_pins_a: assert property (run_s ##0 (o_clk_src == 2'h1) |-> o_osc_pin1_is_clk && !o_osc_pin2_is_clk)
    else $error("external clock pins wrong");
  hsi_pins_a: assert property (run_s ##0 o_clk_src[1] |-> !o_osc_pin1_is_clk && !o_osc_pin2_is_clk)
    else $error("internal source pins not freed");
  cfg_hold_a: assert property (run_s |-> $stable(o_clk_src) && $stable(o_reset_pin_is_reset))
    else $error("settings changed while running");
  port_role_a: assert property (run_s ##0 !o_reset_pin_is_reset |-> !o_sys_reset)
    else $error("port role pin caused reset");
  pin_stall_a: assert property (pin_stall_s |=> !o_nv_req)
    else $error("fetch started with pin low");
  wd_gate_a: assert property (run_s ##0 !o_watchdog_src_slow |-> ##[0:2] !o_watchdog_clk_en)
    else $error("watchdog clock not gated");
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready okay");
endmodule
bind boot_option_byte_decoder boot_cfg_props i_props (.*);

/* tb/boot_option_byte_decoder_bench.sv */
`timescale 1ns/10ps
`include "boot_cfg_map.vh"
module boot_option_byte_decoder_bench;
  logic i_clk = 0, i_rst = 1, i_nv_valid = 0, i_reset_pin = 1, i_osc_tick = 0;
  logic i_halt_mode = 0, i_stop_mode = 0, i_hsel = 0, i_hwrite = 0;
  logic [7:0] i_nv_data = 8'h00, cfg = 8'h90, b;
  logic [11:0] i_haddr = 12'h000;
  logic [1:0] i_htrans = 2'h0, ph = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0, rd;
  wire [31:0] o_hrdata;
  wire [15:0] o_nv_addr;
  wire [1:0] o_clk_src;
  wire o_nv_req, o_hreadyout, o_hresp, o_sys_reset, o_cfg_ready, o_reset_pin_is_reset;
  wire o_reset_pin_port_bit, o_osc_pin1_is_clk, o_osc_pin2_is_clk, o_slow_osc_run;
  wire o_watchdog_clk_en, o_watchdog_src_slow, o_eight_bit_timer_b_clk_en;
  wire i_hready = o_hreadyout;
  integer failures = 0, n_tests = 0;
  boot_option_byte_decoder i_dut (.*);
  always #12.5 i_clk = ~i_clk;
  // memory answers one cycle after request; data scrambled while no request is pending
  always @(posedge i_clk) begin
    i_nv_valid <= o_nv_req && !i_nv_valid;
    i_nv_data <= o_nv_req ? cfg : ~cfg;
    ph <= ph + 2'h1;
    i_osc_tick <= ph[1];
  end
  task chk(input [31:0] seen, input [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task wready(input int n);
    repeat (n) if (o_cfg_ready !== 1'b1) @(posedge i_clk);
  endtask
  // select stays high once used, so no double assignment between transfers
  task bus(input [11:0] a, input w, input [31:0] d);
    i_hsel <= 1;
    i_haddr <= a;
    i_hwrite <= w;
    i_htrans <= `HTRANS_NONSEQ;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    rd = o_hrdata;
  endtask
  task boot(input [7:0] v, input p, input int lim);
    cfg <= v;
    i_rst <= 1;
    i_reset_pin <= p;
    cyc(5);
    i_rst <= 0;
    wready(lim);
  endtask
  task s_src;
    for (int s = 1; s < 4; s++) for (int r = 0; r < 2; r++) begin
      b = {4'h9, r[0], s[1:0], 1'b0};
      boot(b, 1, 20);
      chk(o_cfg_ready, 1);
      chk(o_clk_src, s[1:0]);
      chk({o_osc_pin1_is_clk, o_osc_pin2_is_clk}, (s == 1) ? 2 : 0);
      chk(o_reset_pin_is_reset, r[0]);
      bus(`REG_CFG_BYTE, 0, 0);
      chk(rd[7:0], b);
      bus(`REG_STATUS, 0, 0);
      chk(rd[6:0], {2'b11, r[0], s[1], s == 1, 1'b0, 1'b1});
    end
    bus(12'h0f0, 1, 32'hffffffff);
    bus(12'h0f0, 0, 0);
    chk(rd, 0);
  endtask
  // main osc edge every 4 cycles; wait of 2^e edges
  task s_xtal;
    for (int w = 0; w < 2; w++) begin
      b = {2'b10, w[0], 5'b11001};
      boot(b, 1, (w ? 4096 : 1024) * 3);
      chk(o_cfg_ready, 0);
      wready((w ? 4096 : 1024) + 80);
      chk(o_cfg_ready, 1);
      chk({o_osc_pin1_is_clk, o_osc_pin2_is_clk}, 3);
    end
  endtask
  task s_osc;
    for (int l = 0; l < 2; l++) begin
      boot({7'b1001110, l[0]}, 1, 20);
      i_halt_mode <= 1;
      cyc(4);
      chk(o_watchdog_clk_en, l[0]);
      chk(o_watchdog_src_slow, 1);
      i_halt_mode <= 0;
      i_stop_mode <= 1;
      cyc(4);
      chk(o_eight_bit_timer_b_clk_en, 1);
      chk(o_watchdog_clk_en, l[0]);
      i_stop_mode <= 0;
      bus(`REG_WD_CTRL, 1, 0);
      cyc(3);
      chk(o_watchdog_clk_en, l[0]);
      chk(o_watchdog_src_slow, l[0]);
      bus(`REG_SLOW_OSC, 1, 1);
      cyc(3);
      chk(o_slow_osc_run, l[0]);
      bus(`REG_STATUS, 0, 0);
      chk(rd[5], l[0]);
    end
  endtask
  task s_pin;
    boot(8'h95, 0, 60);
    chk(o_cfg_ready, 0);
    chk(o_sys_reset, 1);
    i_reset_pin <= 1;
    wready(30);
    chk(o_cfg_ready, 1);
    i_reset_pin <= 0;
    cfg <= 8'h90;
    cyc(6);
    chk(o_sys_reset, 0);
    chk(o_reset_pin_port_bit, 0);
    chk(o_clk_src, 2);
    i_reset_pin <= 1;
    cyc(4);
    chk(o_reset_pin_port_bit, 1);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // whole run is some 21k cycles; the 60k-cycle limit allows about triple
  initial begin
    #1500us;
    failures++;
    give_verdict;
  end
  initial begin
    s_src;
    s_xtal;
    s_osc;
    s_pin;
    give_verdict;
  end
endmodule
